// ### vmc_core.sv
`timescale 1ns/1ns
module vmc_core
    import vmc_pkg::*;
#(
    parameter int unsigned PROGRAM_CYCLE = PROGRAM_CYCLE_CLKS
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // configuration
    input wire vmc_cfg_t cfg,
    // measurements, refreshed each program cycle
    input wire vmc_meas_t meas,
    input wire logic [15:0] live_angle,
    input wire logic [15:0] live_amp,
    // blocking matrix input
    input wire logic block_in,
    // memory outputs
    output logic memory_active,
    output logic [15:0] mem_amplitude,
    output logic [15:0] mem_angle,
    output logic freq_from_phase_c,
    // event stream
    output logic memory_event_valid,
    output logic [3:0] memory_event_code
);

    // parameter check
    if (PROGRAM_CYCLE < 2) begin : g_bad_cycle
        $error("program cycle must be at least two clocks");
    end

    // lowest set bit of an event vector
    function automatic logic [2:0] first_set(input logic [5:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = NUM_EV - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    // clamp a value into a window
    function automatic logic [15:0] clamp(input logic [15:0] x, input logic [15:0] lo,
                                          input logic [15:0] hi);
        return (x < lo) ? lo : ((x > hi) ? hi : x);
    endfunction

    vmc_core_t st;
    vmc_core_t next_st;
    logic tick;
    logic low_all;
    logic i_high;
    logic cond;
    logic [15:0] thr_c;
    logic [16:0] limit;
    logic [5:0] new_flags;
    logic [5:0] set_on;
    logic [5:0] set_off;
    logic [5:0] clr_on;
    logic [5:0] clr_off;
    logic [2:0] ev_idx;

    // threshold held within 2 V to 50 V
    assign thr_c = clamp(cfg.memory_low_voltage_threshold, THR_MIN, THR_MAX);

    // duration limit in program cycles
    assign limit = 17'(32'(clamp(cfg.memory_max_duration, DUR_MIN, DUR_MAX)) * TICKS_PER_UNIT);

    // program cycle strobe
    assign tick = (st.tick_cnt == 32'(PROGRAM_CYCLE - 1));

    // voltage collapse check per measurement mode
    vmc_voltage_select u_vsel (
        .mode(cfg.mode),
        .thr(thr_c),
        .meas(meas),
        .all_low(low_all)
    );

    // any phase current above pickup
    assign i_high = (meas.phase_a_current_rms > cfg.current_pickup)
                 || (meas.phase_b_current_rms > cfg.current_pickup)
                 || (meas.phase_c_current_rms > cfg.current_pickup);

    // activation condition
    assign cond = cfg.enable && low_all && (!cfg.phase_current_pickup_condition || i_high);

    // next state
    always_comb begin
        next_st = st;
        next_st.ev_valid = 1'b0;
        new_flags = st.flags;
        set_on = 6'h00;
        set_off = 6'h00;
        clr_on = 6'h00;
        clr_off = 6'h00;
        ev_idx = 3'h0;
        next_st.tick_cnt = tick ? 32'h0 : st.tick_cnt + 32'h1;
        if (tick) begin
            // blocking sampled once per program cycle
            next_st.block_s = block_in;
            if (!cfg.enable || block_in) begin
                next_st.state = st_idle;
            end else begin
                case (st.state)
                    st_idle: begin
                        if (cond) begin
                            next_st.state = st_active;
                            next_st.dur_cnt = 17'h0;
                        end
                    end
                    st_active: begin
                        if (!cond) begin
                            next_st.state = st_idle;
                        end else if (st.dur_cnt + 17'h1 >= limit) begin
                            next_st.state = st_expired;
                        end else begin
                            next_st.dur_cnt = st.dur_cnt + 17'h1;
                        end
                    end
                    st_expired: begin
                        if (!cond) begin
                            next_st.state = st_idle;
                        end
                    end
                    default: next_st.state = st_idle;
                endcase
            end
            // pre-fault angle tracked while voltages are healthy
            if (st.state != st_active && !low_all) begin
                next_st.held_angle = live_angle;
            end
            // frequency from phase c current while voltages are gone
            next_st.ct_track = cfg.current_based_freq_tracking && cfg.enable && low_all;
            // event flag vector
            new_flags[EV_ENABLE] = cfg.enable;
            new_flags[EV_LOW_V] = low_all;
            new_flags[EV_HIGH_I] = i_high;
            new_flags[EV_CT_TRACK] = next_st.ct_track;
            new_flags[EV_IN_USE] = (next_st.state == st_active);
            new_flags[EV_BLOCKED] = block_in;
            next_st.flags = new_flags;
            set_on = new_flags & ~st.flags & cfg.store_on;
            set_off = ~new_flags & st.flags & cfg.store_off;
        end
        // memory substitutes amplitude and angle while active
        if (next_st.state == st_active) begin
            next_st.out_amp = thr_c;
            next_st.out_angle = next_st.held_angle;
        end else begin
            next_st.out_amp = live_amp;
            next_st.out_angle = live_angle;
        end
        // drain one pending event per clock, on events first
        if (|st.pend_on) begin
            ev_idx = first_set(st.pend_on);
            clr_on[ev_idx] = 1'b1;
            next_st.ev_valid = 1'b1;
            next_st.ev_code = {ev_idx, 1'b1};
        end else if (|st.pend_off) begin
            ev_idx = first_set(st.pend_off);
            clr_off[ev_idx] = 1'b1;
            next_st.ev_valid = 1'b1;
            next_st.ev_code = {ev_idx, 1'b0};
        end
        // a new event wins over the clear of the same bit
        next_st.pend_on = (st.pend_on & ~clr_on) | set_on;
        next_st.pend_off = (st.pend_off & ~clr_off) | set_off;
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st <= CORE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign memory_active = (st.state == st_active);
    assign mem_amplitude = st.out_amp;
    assign mem_angle = st.out_angle;
    assign freq_from_phase_c = st.ct_track;
    assign memory_event_valid = st.ev_valid;
    assign memory_event_code = st.ev_code;

    // disabled at a program cycle means inactive after it
    a_disable_inactive:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        tick && !cfg.enable |=> !memory_active)
    else $error("memory active while disabled");

    // sampled blocking keeps memory off and is reported
    a_block_holds_off:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        tick && block_in |=> !memory_active && st.block_s && st.flags[EV_BLOCKED])
    else $error("memory active while blocked");

    // blocking sample changes only at a program cycle
    a_block_sampled:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        !tick |=> $stable(st.block_s))
    else $error("blocking sample moved between program cycles");

    // activation only follows collapsed voltages
    a_rise_needs_low:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(memory_active) |-> $past(low_all) && $past(tick))
    else $error("memory activated without low voltage");

    // activation honours the current condition
    a_rise_needs_current:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(memory_active) && $past(cfg.phase_current_pickup_condition) |-> $past(i_high))
    else $error("memory activated without high current");

    // amplitude equals threshold while active
    a_amp_threshold:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        memory_active && $stable(thr_c) |-> mem_amplitude == thr_c)
    else $error("amplitude not the activation threshold");

    // angle frozen during memory use
    a_angle_frozen:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        memory_active && $past(memory_active) |-> $stable(mem_angle))
    else $error("angle moved while memory active");

    // threshold stays in its window
    a_thr_window:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        thr_c >= THR_MIN && thr_c <= THR_MAX)
    else $error("threshold outside two to fifty volts");

    // duration counter never reaches the limit while active
    a_dur_limit:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        memory_active && $stable(limit) |-> st.dur_cnt < limit)
    else $error("memory active beyond maximum duration");

    // tracking output follows low voltages and the switch
    a_ct_tracking:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        tick |=> freq_from_phase_c == $past(cfg.current_based_freq_tracking
                                            && cfg.enable && low_all))
    else $error("phase c tracking mismatch");

    // emitted events were selected for storage
    a_event_selected:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        memory_event_valid |-> $past(|(st.pend_on | st.pend_off)))
    else $error("event emitted with nothing pending");

endmodule

// ### vmc_pkg.sv
// Behaviour
// - a configuration switch enables the memory; disabled means never active.
// - activation needs every voltage in use below the activation threshold.
// - optional current condition also needs one phase current above pickup.
// - activation threshold spans two to fifty volts AC.
// - while active, amplitude output is the activation threshold value.
// - while active, angle output is the angle captured just before activation.
// - a memory-active output is high exactly while the memory is active.
// - blocking input is sampled once at each program cycle start.
// - activation uses RMS currents and up to four voltages on 5 ms base.
// - both three-phase modes use voltage channels A, B and C.
// - two-channel line mode uses channels A and B, voltages 12 and 32.
// - two-channel plus residual mode uses calculated phase-to-neutral voltages.
// - memory use ends after a maximum time of 0.02 to 50.00 s.
// - forced current tracking takes frequency from phase C when voltages vanish.
// - on and off events for six conditions, each selectable for storage.
package vmc_pkg;

    // clock and program cycle
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned TIME_BASE_MS = 5;
    localparam int unsigned PROGRAM_CYCLE_CLKS = CLK_HZ / 1000 * TIME_BASE_MS;

    // voltages in 10 mV steps, threshold limits 2 V and 50 V
    localparam logic [15:0] THR_MIN = 16'h00c8;
    localparam logic [15:0] THR_MAX = 16'h1388;

    // maximum duration in 10 ms steps, 0.02 s to 50.00 s
    localparam int unsigned DUR_UNIT_MS = 10;
    localparam int unsigned TICKS_PER_UNIT = DUR_UNIT_MS / TIME_BASE_MS;
    localparam logic [15:0] DUR_MIN = 16'h0002;
    localparam logic [15:0] DUR_MAX = 16'h1388;

    // event sources, bit positions of the flag vector
    localparam int unsigned NUM_EV = 6;
    localparam int unsigned EV_ENABLE = 0;
    localparam int unsigned EV_LOW_V = 1;
    localparam int unsigned EV_HIGH_I = 2;
    localparam int unsigned EV_CT_TRACK = 3;
    localparam int unsigned EV_IN_USE = 4;
    localparam int unsigned EV_BLOCKED = 5;

    // voltage measurement modes
    typedef enum logic [1:0] {
        three_phase_neutral_mode = 2'h0,
        three_phase_line_mode = 2'h1,
        two_channel_line_mode = 2'h2,
        two_channel_plus_residual_mode = 2'h3
    } vmc_mode_t;

    // memory states
    typedef enum logic [2:0] {
        st_idle = 3'h1,
        st_active = 3'h2,
        st_expired = 3'h4
    } vmc_state_t;

    // configuration bundle
    typedef struct packed {
        logic enable;
        vmc_mode_t mode;
        logic phase_current_pickup_condition;
        logic current_based_freq_tracking;
        logic [15:0] memory_low_voltage_threshold;
        logic [15:0] current_pickup;
        logic [15:0] memory_max_duration;
        logic [5:0] store_on;
        logic [5:0] store_off;
    } vmc_cfg_t;

    // RMS measurement bundle
    typedef struct packed {
        logic [15:0] phase_a_current_rms;
        logic [15:0] phase_b_current_rms;
        logic [15:0] phase_c_current_rms;
        logic [15:0] voltage_ch1_rms;
        logic [15:0] voltage_ch2_rms;
        logic [15:0] voltage_ch3_rms;
        logic [15:0] voltage_ch4_rms;
    } vmc_meas_t;

    // complete state of the core
    typedef struct packed {
        logic [31:0] tick_cnt;
        vmc_state_t state;
        logic block_s;
        logic [16:0] dur_cnt;
        logic [15:0] held_angle;
        logic [15:0] out_angle;
        logic [15:0] out_amp;
        logic ct_track;
        logic [5:0] flags;
        logic [5:0] pend_on;
        logic [5:0] pend_off;
        logic ev_valid;
        logic [3:0] ev_code;
    } vmc_core_t;

    localparam vmc_core_t CORE_RESET = '{state: st_idle, default: '0};

endpackage

// ### vmc_voltage_select.sv
`timescale 1ns/1ns
module vmc_voltage_select
    import vmc_pkg::*;
(
    // mode and threshold
    input wire vmc_mode_t mode,
    input wire logic [15:0] thr,
    // voltage channels
    input wire vmc_meas_t meas,
    // result
    output logic all_low
);

    // divide by three by multiply and shift, truncated; rounds down below 131072, can come out one high above
    function automatic logic [17:0] div3(input logic [17:0] x);
        logic [35:0] p;
        p = 36'(x) * 36'h0aaab;
        return 18'(p >> 17);
    endfunction

    logic [17:0] v1;
    logic [17:0] v2;
    logic [17:0] v3;
    logic [17:0] v4;
    logic [17:0] ua;
    logic [17:0] ub;
    logic [17:0] uc;
    logic [17:0] t;

    assign v1 = 18'(meas.voltage_ch1_rms);
    assign v2 = 18'(meas.voltage_ch2_rms);
    assign v3 = 18'(meas.voltage_ch3_rms);
    assign v4 = 18'(meas.voltage_ch4_rms);
    assign t = 18'(thr);

    // phase-to-neutral upper bounds from two line voltages and residual
    assign ua = div3(18'(v1 + v1 + v2)) + v4;
    assign ub = div3(18'(v1 + v2)) + v4;
    assign uc = div3(18'(v1 + v2 + v2)) + v4;

    // every voltage of the active mode must sit below threshold
    always_comb begin
        case (mode)
            three_phase_neutral_mode,
            three_phase_line_mode: all_low = (v1 < t) && (v2 < t) && (v3 < t);
            two_channel_line_mode: all_low = (v1 < t) && (v2 < t);
            two_channel_plus_residual_mode: all_low = (ua < t) && (ub < t) && (uc < t);
            default: all_low = 1'b0;
        endcase
    end

endmodule

// ### vmc_meas_model.sv
`timescale 1ns/1ns
module vmc_meas_model
    import vmc_pkg::*;
#(
    parameter int unsigned PROGRAM_CYCLE = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // wanted channel values
    input wire vmc_meas_t tgt_meas,
    input wire logic [15:0] tgt_angle,
    input wire logic [15:0] tgt_amp,
    input wire logic angle_lost,
    // presented measurements
    output vmc_meas_t meas,
    output logic [15:0] live_angle,
    output logic [15:0] live_amp
);
    logic [31:0] phase;

    // rms refresh once per time base, mid cycle so it is steady at the strobe
    always @(posedge core_clk) begin
        if (!rst_b) begin
            phase <= '0;
            meas <= '0;
            live_angle <= '0;
            live_amp <= '0;
        end else begin
            phase <= (phase == PROGRAM_CYCLE - 1) ? '0 : phase + 1;
            if (phase == PROGRAM_CYCLE / 2) begin
                meas <= tgt_meas;
            end
            live_amp <= tgt_amp;
            // without voltage the angle is not measurable and wanders
            live_angle <= angle_lost ? live_angle + 16'h0101 : tgt_angle;
        end
    end
endmodule

// ### test_vmc_core.sv
`timescale 1ns/1ns
module test_vmc_core;
    import vmc_pkg::*;
    localparam int unsigned PC = 8;
    localparam logic [15:0] HI = 16'h2710;
    localparam logic [15:0] LO = 16'h0010;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic block_in = 1'b0;
    logic lost = 1'b0;
    vmc_cfg_t cfg;
    vmc_meas_t tgt, meas;
    logic [15:0] live_angle, live_amp, mem_amplitude, mem_angle;
    logic memory_active, freq_from_phase_c, memory_event_valid;
    logic [3:0] memory_event_code;
    logic [15:0] ev_seen;
    logic [31:0] ph = '0;
    int fails = 0;
    int tests_run = 0;
    // {expected, mode, low channel mask ch4..ch1}
    logic [6:0] modes [7] = '{7'h0b, 7'h1b, 7'h57, 7'h63, 7'h2d, 7'h7b, 7'h37};

    // clock and a mirror of the program cycle phase
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        ph <= (!rst_b || ph == PC - 1) ? 32'h0 : ph + 1;
    end
    // record every event code that comes out
    always @(posedge core_clk) begin
        if (memory_event_valid === 1'b1) begin
            ev_seen[memory_event_code] <= 1'b1;
        end
    end

    vmc_core #(.PROGRAM_CYCLE(PC)) vmc_core_inst (
        .core_clk(core_clk), .rst_b(rst_b), .cfg(cfg), .meas(meas),
        .live_angle(live_angle), .live_amp(live_amp), .block_in(block_in),
        .memory_active(memory_active), .mem_amplitude(mem_amplitude),
        .mem_angle(mem_angle), .freq_from_phase_c(freq_from_phase_c),
        .memory_event_valid(memory_event_valid), .memory_event_code(memory_event_code)
    );
    vmc_meas_model #(.PROGRAM_CYCLE(PC)) vmc_meas_model_inst (
        .core_clk(core_clk), .rst_b(rst_b), .tgt_meas(tgt), .tgt_angle(16'h1234),
        .tgt_amp(16'h4e20), .angle_lost(lost), .meas(meas), .live_angle(live_angle),
        .live_amp(live_amp)
    );

    // compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic done(input string name);
        $display("test %s finished, mismatches so far %0d", name, fails);
    endtask
    // step just past n program cycle strobes
    task automatic next_tick(input int n);
        int i;
        repeat (n) begin
            i = 0;
            do begin
                @(posedge core_clk);
                #1;
                i++;
            end while (ph != 0 && i < 2 * PC);
            if (ph != 0) begin
                fails++;
                $display("MISMATCH at %0t: no program cycle strobe", $time);
                finish_test();
            end
        end
    endtask
    // set voltage channels, low where the mask bit is set
    task automatic volts(input logic [3:0] m);
        tgt.voltage_ch1_rms = m[0] ? LO : HI;
        tgt.voltage_ch2_rms = m[1] ? LO : HI;
        tgt.voltage_ch3_rms = m[2] ? LO : HI;
        tgt.voltage_ch4_rms = m[3] ? LO : HI;
        lost = (m == 4'hf);
    endtask

    initial begin
        logic [15:0] n;
        cfg = '0;
        cfg.enable = 1'b1;
        cfg.memory_low_voltage_threshold = 16'h0bb8;
        cfg.current_pickup = 16'h0064;
        cfg.memory_max_duration = 16'h1388;
        cfg.store_on = 6'h3f;
        cfg.store_off = 6'h3f;
        tgt = '0;
        ev_seen = '0;
        volts(4'h0);
        repeat (20) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        check(16'(memory_active), 16'h0000);
        check(16'(memory_event_valid), 16'h0000);
        // switch off: a full collapse must not start the memory
        cfg.enable = 1'b0;
        volts(4'hf);
        next_tick(3);
        check(16'(memory_active), 16'h0000);
        done("disable");
        // collapse with healthy pre-fault angle
        volts(4'h0);
        cfg.enable = 1'b1;
        next_tick(2);
        ev_seen = '0;
        volts(4'hf);
        next_tick(2);
        check(16'(memory_active), 16'h0001);
        check(mem_amplitude, 16'h0bb8);
        check(mem_angle, 16'h1234);
        check(16'({ev_seen[4'h3], ev_seen[4'h9]}), 16'h0003);
        cfg.memory_low_voltage_threshold = 16'h0064;
        next_tick(1);
        check(mem_amplitude, THR_MIN);
        cfg.memory_low_voltage_threshold = 16'h0bb8;
        volts(4'h0);
        next_tick(2);
        check(16'(memory_active), 16'h0000);
        check(16'(ev_seen[4'h8]), 16'h0001);
        check(mem_amplitude, 16'h4e20);
        check(mem_angle, 16'h1234);
        done("activation");
        // channels in use for each measurement mode
        for (int k = 0; k < 7; k++) begin
            cfg.mode = vmc_mode_t'(modes[k][5:4]);
            volts(modes[k][3:0]);
            next_tick(2);
            check(16'(memory_active), 16'(modes[k][6]));
            volts(4'h0);
            next_tick(2);
        end
        cfg.mode = three_phase_neutral_mode;
        done("modes");
        // current condition, equal to pickup is not above it
        cfg.phase_current_pickup_condition = 1'b1;
        tgt.phase_a_current_rms = 16'h0064;
        volts(4'hf);
        next_tick(2);
        check(16'(memory_active), 16'h0000);
        ev_seen = '0;
        tgt.phase_b_current_rms = 16'h00c8;
        next_tick(2);
        check(16'(memory_active), 16'h0001);
        check(16'(ev_seen[4'h5]), 16'h0001);
        cfg.current_based_freq_tracking = 1'b1;
        next_tick(1);
        check(16'(freq_from_phase_c), 16'h0001);
        cfg.current_based_freq_tracking = 1'b0;
        next_tick(1);
        check(16'(freq_from_phase_c), 16'h0000);
        done("current");
        // a block pulse between strobes is never seen
        block_in = 1'b1;
        repeat (PC - 3) @(posedge core_clk);
        #1;
        block_in = 1'b0;
        next_tick(1);
        check(16'(memory_active), 16'h0001);
        ev_seen = '0;
        block_in = 1'b1;
        next_tick(2);
        check(16'(memory_active), 16'h0000);
        check(16'(ev_seen[4'hb]), 16'h0001);
        block_in = 1'b0;
        next_tick(2);
        check(16'(memory_active), 16'h0001);
        done("block");
        // shortest maximum duration, in-use on event not stored
        cfg.phase_current_pickup_condition = 1'b0;
        cfg.memory_max_duration = 16'h0002;
        cfg.store_on = 6'h2f;
        volts(4'h0);
        next_tick(2);
        ev_seen = '0;
        volts(4'hf);
        n = '0;
        repeat (10 * PC) begin
            @(posedge core_clk);
            #1;
            n = n + 16'(memory_active === 1'b1);
        end
        check(n, 16'(4 * PC));
        check(16'(memory_active), 16'h0000);
        check(16'(ev_seen[4'h9]), 16'h0000);
        check(16'(ev_seen[4'h8]), 16'h0001);
        volts(4'h0);
        next_tick(2);
        volts(4'hf);
        next_tick(2);
        check(16'(memory_active), 16'h0001);
        done("duration");
        finish_test();
    end
endmodule
